/* dv/meter_host_model.sv */
// Purpose: far-side model, measurement engine and serial character sink
// Assumes: one clock, synchronous active-high reset
// Notes: tx_ready toggles every cycle so the sender must hold each character

`timescale 1ns/1ps
`default_nettype none

module meter_host_model #(
  parameter int DONE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic meas_start,
  input wire logic dev_clear,
  input wire logic tx_valid,
  input wire logic [7:0] tx_char,
  output logic meas_done,
  output logic tx_ready
);
  int run_left = 0;
  int start_count = 0;
  int clear_count = 0;
  logic [7:0] rx_chars[$];

  // ------------------------------------------------------------
  // engine and sink
  // ------------------------------------------------------------
  always @(posedge clk) begin
    meas_done <= 1'b0;
    if (reset) begin
      run_left <= 0;
      tx_ready <= 1'b0;
    end else begin
      // stalls every other cycle to test holding
      tx_ready <= ~tx_ready;
      if (tx_valid && tx_ready) rx_chars.push_back(tx_char);
      if (dev_clear) clear_count <= clear_count + 1;
      if (meas_start) begin
        start_count <= start_count + 1;
        run_left <= DONE_CYCLES;
      end else if (run_left == 1) begin
        meas_done <= 1'b1;
        run_left <= 0;
      end else if (run_left > 1) begin
        run_left <= run_left - 1;
      end
    end
  end
endmodule : meter_host_model

`default_nettype wire

/* dv/trigger_remote_ctrl_test.sv */
// Purpose: self-checking bench of the trigger and remote-state handler
// Assumes: commands are one-cycle strobes driven just after the rising edge
// Notes: levels are sampled a few cycles after a command, not at its edge

`timescale 1ns/1ps
`default_nettype none

module trigger_remote_ctrl_test
  import trig_ctrl_pkg::*;
;
  localparam int LIMIT_NS = 40000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic [3:0] cmd_code = 4'h0;
  logic [7:0] cmd_arg = 8'h00;
  logic cmd_iface = 1'b0;
  logic serial_enabled = 1'b1;
  logic rear_trig_in = 1'b1;
  logic err_read = 1'b0;
  logic err_clear = 1'b0;
  logic meas_done, tx_ready, meas_start, meas_settle, meas_busy, resp_valid, dev_clear, tx_valid;
  logic remote, lockout, keys_enabled, local_key_enabled, show_local_label, show_locked, err_valid;
  logic [2:0] trig_type;
  logic [31:0] resp_data;
  logic [7:0] tx_char;
  logic [15:0] err_code;
  logic [4:0] err_count;
  logic [15:0] got_code = 16'h0000;
  int bad_count = 0;
  int compares = 0;
  int resp_seen = 0;
  int s;
  logic [3:0] panel_cmd [4] = '{CMD_REMOTE_STATE, CMD_REMOTE_LOCKOUT, CMD_LOCAL_STATE, CMD_LOCAL_LOCKOUT};
  logic [5:0] panel_exp [4] = '{6'h26, 6'h31, 6'h0c, 6'h10};
  logic [7:0] reply [6] = '{CHAR_CR, CHAR_LF, CHAR_EQ, CHAR_GT, CHAR_CR, CHAR_LF};

  always #2 clk = ~clk;
  always @(posedge clk) if (err_valid === 1'b1) got_code <= err_code;
  // counts answer pulses, so a stuck-high valid shows up as too many
  always @(posedge clk) if (resp_valid === 1'b1) resp_seen <= resp_seen + 1;

  trigger_remote_ctrl i_trigger_remote_ctrl (.clk, .reset, .cmd_valid, .cmd_code, .cmd_arg, .cmd_iface,
    .serial_enabled, .rear_trig_in, .meas_done, .tx_ready, .err_read, .err_clear, .trig_type, .meas_start,
    .meas_settle, .meas_busy, .resp_valid, .resp_data, .dev_clear, .tx_valid, .tx_char, .remote, .lockout,
    .keys_enabled, .local_key_enabled, .show_local_label, .show_locked, .err_valid, .err_code, .err_count);
  meter_host_model i_meter_host_model (.clk, .reset, .meas_start, .dev_clear, .tx_valid, .tx_char,
    .meas_done, .tx_ready);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic cmd(input logic [3:0] code, input logic [7:0] arg, input logic iface);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_arg <= arg;
    cmd_iface <= iface;
    @(posedge clk);
    cmd_valid <= 1'b0;
    idle(3);
  endtask : cmd

  task automatic pulse_read();
    @(posedge clk);
    err_read <= 1'b1;
    @(posedge clk);
    err_read <= 1'b0;
    idle(3);
  endtask : pulse_read

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    idle(16);
    reset <= 1'b0;
    idle(1);
    check("reset type", trig_type, TRIG_RESET);
    check("reset panel", {remote, lockout, keys_enabled, local_key_enabled}, 4'h3);
    idle(60);
    check("internal runs", i_meter_host_model.start_count > 1, 1'b1);
    $display("test reset done");
    for (int t = 2; t <= 5; t++) begin
      cmd(CMD_SET_TRIG, 8'(t), IFACE_SERIAL);
      idle(30);
      s = i_meter_host_model.start_count;
      idle(30);
      check("no self start", i_meter_host_model.start_count, s);
      check("idle", meas_busy, 1'b0);
      cmd(CMD_STAR_TRG, 8'h00, 1'(t % 2));
      check("star trigger", i_meter_host_model.start_count, s + 1);
      check("busy", meas_busy, 1'b1);
      check("settle", meas_settle, 1'(t == 3 || t == 5));
      cmd(CMD_QUERY_TRIG, 8'h00, IFACE_BUS);
      check("query", resp_data, 32'(t));
      idle(30);
    end
    $display("test types done");
    s = i_meter_host_model.start_count;
    cmd(CMD_BUS_GET, 8'h00, IFACE_SERIAL);
    check("get serial", i_meter_host_model.start_count, s);
    cmd(CMD_BUS_GET, 8'h00, IFACE_BUS);
    check("get bus", i_meter_host_model.start_count, s + 1);
    idle(30);
    cmd(CMD_STAR_TRG, 8'h00, IFACE_SERIAL);
    cmd(CMD_STAR_TRG, 8'h00, IFACE_BUS);
    rear_trig_in <= 1'b0;
    idle(10);
    rear_trig_in <= 1'b1;
    check("busy drops", i_meter_host_model.start_count, s + 2);
    idle(30);
    rear_trig_in <= 1'b0;
    idle(10);
    rear_trig_in <= 1'b1;
    check("rear edge", i_meter_host_model.start_count, s + 3);
    idle(30);
    $display("test sources done");
    cmd(CMD_ABORT, 8'h00, IFACE_SERIAL);
    idle(30);
    check("clear", i_meter_host_model.clear_count, 1);
    check("reply len", i_meter_host_model.rx_chars.size(), 6);
    for (int i = 0; i < 6 && i < i_meter_host_model.rx_chars.size(); i++)
      check("reply char", i_meter_host_model.rx_chars[i], reply[i]);
    cmd(CMD_SERIAL_QUERY, 8'h00, IFACE_SERIAL);
    check("serial number", resp_data, SERIAL_NUMBER);
    check("answers", resp_seen, 5);
    $display("test abort done");
    serial_enabled <= 1'b0;
    cmd(CMD_REMOTE_STATE, 8'h00, IFACE_SERIAL);
    check("panel refused", remote, 1'b0);
    serial_enabled <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      cmd(panel_cmd[i], 8'h00, IFACE_SERIAL);
      check("panel", {remote, lockout, keys_enabled, local_key_enabled, show_local_label, show_locked},
        panel_exp[i]);
    end
    $display("test panel done");
    foreach (reply[i]) cmd(CMD_SET_TRIG, reply[i], IFACE_SERIAL);
    check("bad type kept", trig_type, TRIG_EXT_DELAY_B);
    check("bad type count", err_count, 5'h06);
    err_clear <= 1'b1;
    idle(1);
    err_clear <= 1'b0;
    idle(2);
    for (int i = 0; i < 17; i++) cmd(CMD_SET_TRIG, 8'(i % 2 * 6), IFACE_SERIAL);
    check("queue full", err_count, ERRQ_FULL);
    for (int i = 0; i < 16; i++) begin
      pulse_read();
      if (i == 0) check("first error", got_code, ERR_EXEC);
    end
    check("overflow code", got_code, ERR_TOO_MANY);
    pulse_read();
    check("empty read", got_code, ERR_NONE);
    $display("test errors done");
    finish_test();
  end

  initial begin
    #LIMIT_NS;
    bad_count++;
    finish_test();
  end
endmodule : trigger_remote_ctrl_test

`default_nettype wire

/* rtl/error_queue.sv */
// Purpose: shared constants and the execution error queue of the trigger and remote-state handler
// Assumes: one clock, synchronous active-high reset; push and read come from logic on the same clock
// Notes: depth is fixed at sixteen entries; the overflow marker takes the last slot

package trig_ctrl_pkg;
  // ----------------------------------------------------------------
  // commands, decoded upstream from the host's character stream
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_SET_TRIG = 4'h1;
  localparam logic [3:0] CMD_QUERY_TRIG = 4'h2;
  localparam logic [3:0] CMD_STAR_TRG = 4'h3;
  localparam logic [3:0] CMD_BUS_GET = 4'h4;
  localparam logic [3:0] CMD_ABORT = 4'h5;
  localparam logic [3:0] CMD_SERIAL_QUERY = 4'h6;
  localparam logic [3:0] CMD_REMOTE_STATE = 4'h7;
  localparam logic [3:0] CMD_REMOTE_LOCKOUT = 4'h8;
  localparam logic [3:0] CMD_LOCAL_STATE = 4'h9;
  localparam logic [3:0] CMD_LOCAL_LOCKOUT = 4'ha;
  localparam logic IFACE_SERIAL = 1'b0;
  localparam logic IFACE_BUS = 1'b1;
  // ----------------------------------------------------------------
  // trigger types
  // ----------------------------------------------------------------
  localparam logic [2:0] TRIG_INTERNAL = 3'h1;
  localparam logic [2:0] TRIG_EXT_NODELAY = 3'h2;
  localparam logic [2:0] TRIG_EXT_DELAY = 3'h3;
  localparam logic [2:0] TRIG_EXT_NODELAY_B = 3'h4;
  localparam logic [2:0] TRIG_EXT_DELAY_B = 3'h5;
  localparam logic [2:0] TRIG_RESET = TRIG_INTERNAL;
  localparam logic [7:0] TRIG_ARG_MIN = 8'h01;
  localparam logic [7:0] TRIG_ARG_MAX = 8'h05;
  // ----------------------------------------------------------------
  // error queue
  // ----------------------------------------------------------------
  localparam int ERRQ_DEPTH = 16;
  localparam logic [4:0] ERRQ_FULL = 5'h10;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_TOO_MANY = 16'hfea2;
  localparam logic [15:0] ERR_EXEC = 16'hff38;
  // ----------------------------------------------------------------
  // abort reply and identity
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_LF = 8'h0a;
  localparam logic [7:0] CHAR_EQ = 8'h3d;
  localparam logic [7:0] CHAR_GT = 8'h3e;
  localparam logic [2:0] ABORT_LAST = 3'h5;
  // arbitrary value, stands in for the unit's serial number
  localparam logic [31:0] SERIAL_NUMBER = 32'h0000_1234;
endpackage : trig_ctrl_pkg

`timescale 1ns/1ps
`default_nettype none

module error_queue
  import trig_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic push,
  input wire logic [15:0] push_code,
  input wire logic pop,
  input wire logic clear,
  output logic pop_valid,
  output logic [15:0] pop_code,
  output logic [4:0] count
);
  logic [15:0] mem [ERRQ_DEPTH];
  logic [15:0] next_mem [ERRQ_DEPTH];
  logic [3:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [4:0] next_count;
  logic stuck, next_stuck, next_pop_valid;
  logic [15:0] next_pop_code;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_stuck = stuck;
    next_pop_valid = pop;
    next_pop_code = pop_code;
    if (clear) begin
      next_wr_ptr = 4'h0;
      next_rd_ptr = 4'h0;
      next_count = 5'h00;
      next_stuck = 1'b0;
      next_pop_valid = 1'b0;
    end else begin
      if (pop) begin
        // an empty queue answers with the no-error code
        next_pop_code = (count == 5'h00) ? ERR_NONE : mem[rd_ptr];
        if (count != 5'h00) begin
          next_rd_ptr = rd_ptr + 4'h1;
          next_count = count - 5'h01;
          next_stuck = 1'b0;
        end
      end
      // a read frees a slot, so a push in the same cycle is stored normally unless the overflow marker is already set
      if (push && !stuck) begin
        if (count == ERRQ_FULL && !pop) begin
          next_mem[wr_ptr - 4'h1] = ERR_TOO_MANY;
          next_stuck = 1'b1;
        end else begin
          next_mem[wr_ptr] = push_code;
          next_wr_ptr = wr_ptr + 4'h1;
          next_count = next_count + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < ERRQ_DEPTH; i++) begin
        mem[i] <= ERR_NONE;
      end
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count <= 5'h00;
      stuck <= 1'b0;
      pop_valid <= 1'b0;
      pop_code <= ERR_NONE;
    end else begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      stuck <= next_stuck;
      pop_valid <= next_pop_valid;
      pop_code <= next_pop_code;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_errq_bound;
    @(posedge clk) disable iff (reset) count <= ERRQ_FULL;
  endproperty
  a_errq_bound: assert property (p_errq_bound) else $error("error queue over sixteen entries");

  property p_errq_overflow;
    @(posedge clk) disable iff (reset)
      (push && !pop && !clear && !stuck && count == ERRQ_FULL) |=> (stuck && count == ERRQ_FULL);
  endproperty
  a_errq_overflow: assert property (p_errq_overflow) else $error("overflow did not mark queue");
endmodule : error_queue

`default_nettype wire

/* rtl/trigger_remote_ctrl.sv */
// Purpose: trigger type selection, trigger sourcing and remote/local panel state of the meter
// Assumes: commands arrive already decoded as one-cycle strobes; rear jack is asynchronous
// Notes: measurement engine reports completion on meas_done; only one measurement runs at a time
//
// Behaviour
// - trigger type 1 to 5 accepted; other values raise execution error, type kept
// - type 1 triggers continuously internally; types 2 to 5 use external sources only
// - rear trigger jack stays enabled for all five trigger types
// - settling delay applied only for types 3 and 5
// - trigger type query returns the most recently accepted type
// - measurement starts only on a trigger event from the selected source
// - external types start a measurement on each falling rear jack edge that arrives while no measurement is busy
// - star trigger command triggers over either interface
// - bus group trigger acts only on the instrument bus, not serial
// - abort character does device clear and sends CR LF => CR LF
// - identification query returns the serial number
// - remote/local state commands accepted only with serial interface enabled
// - remote state disables all keys except local, shows LOCAL label
// - remote with lockout disables every key and shows LOCKED
// - local state enables every key, no lockout
// - local with lockout keeps every key disabled
// - execution errors queue sixteen deep; overflow marks last entry -350

`timescale 1ns/1ps
`default_nettype none

module trigger_remote_ctrl
  import trig_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [7:0] cmd_arg,
  input wire logic cmd_iface,
  input wire logic serial_enabled,
  input wire logic rear_trig_in,
  input wire logic meas_done,
  input wire logic tx_ready,
  input wire logic err_read,
  input wire logic err_clear,
  output logic [2:0] trig_type,
  output logic meas_start,
  output logic meas_settle,
  output logic meas_busy,
  output logic resp_valid,
  output logic [31:0] resp_data,
  output logic dev_clear,
  output logic tx_valid,
  output logic [7:0] tx_char,
  output logic remote,
  output logic lockout,
  output logic keys_enabled,
  output logic local_key_enabled,
  output logic show_local_label,
  output logic show_locked,
  output logic err_valid,
  output logic [15:0] err_code,
  output logic [4:0] err_count
);
  typedef enum logic [1:0] {
    PANEL_LOCAL = 2'b00, PANEL_REMOTE = 2'b01, PANEL_REMOTE_LOCK = 2'b10, PANEL_LOCAL_LOCK = 2'b11
  } panel_t;
  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;

  function automatic logic [7:0] abort_char_at(input logic [2:0] idx);
    unique case (idx)
      3'h0, 3'h4: abort_char_at = CHAR_CR;
      3'h2: abort_char_at = CHAR_EQ;
      3'h3: abort_char_at = CHAR_GT;
      default: abort_char_at = CHAR_LF;
    endcase
  endfunction : abort_char_at
  function automatic logic has_delay(input logic [2:0] t);
    has_delay = (t == TRIG_EXT_DELAY) || (t == TRIG_EXT_DELAY_B);
  endfunction : has_delay
  function automatic logic is_cmd(input logic v, input logic [3:0] c, input logic [3:0] want);
    is_cmd = v && (c == want);
  endfunction : is_cmd

  // ----------------------------------------------------------------
  // rear jack synchroniser and falling-edge filter
  // ----------------------------------------------------------------
  logic rear_s1, rear_s2, rear_s3, rear_level, next_rear_level, rear_fall;

  always_comb begin
    // only take a new level once the second and third stages agree
    next_rear_level = (rear_s2 == rear_s3) ? rear_s3 : rear_level;
    rear_fall = rear_level && !next_rear_level;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rear_s1 <= 1'b1;
      rear_s2 <= 1'b1;
      rear_s3 <= 1'b1;
      rear_level <= 1'b1;
    end else begin
      rear_s1 <= rear_trig_in;
      rear_s2 <= rear_s1;
      rear_s3 <= rear_s2;
      rear_level <= next_rear_level;
    end
  end

  // ----------------------------------------------------------------
  // trigger type, triggering and measurement start
  // ----------------------------------------------------------------
  logic [2:0] next_trig_type;
  logic next_meas_start, next_meas_settle, next_meas_busy;
  logic next_err_push, err_push, type_ok, trig_event, ext_type, clear_now;

  always_comb begin
    type_ok = (cmd_arg >= TRIG_ARG_MIN) && (cmd_arg <= TRIG_ARG_MAX);
    ext_type = (trig_type != TRIG_INTERNAL);
    clear_now = is_cmd(cmd_valid, cmd_code, CMD_ABORT) && cmd_iface == IFACE_SERIAL;
    next_trig_type = (is_cmd(cmd_valid, cmd_code, CMD_SET_TRIG) && type_ok) ? cmd_arg[2:0] : trig_type;
    next_err_push = is_cmd(cmd_valid, cmd_code, CMD_SET_TRIG) && !type_ok;
    trig_event = rear_fall
      || (!ext_type)
      || (ext_type && is_cmd(cmd_valid, cmd_code, CMD_STAR_TRG))
      || (ext_type && is_cmd(cmd_valid, cmd_code, CMD_BUS_GET) && cmd_iface == IFACE_BUS);
    // a trigger while busy is dropped, not held back for later
    next_meas_start = trig_event && !meas_busy && !clear_now;
    next_meas_settle = next_meas_start ? has_delay(trig_type) : meas_settle;
    // abort beats a start, a start beats a completion
    next_meas_busy = !clear_now && (next_meas_start || (meas_busy && !meas_done));
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trig_type <= TRIG_RESET;
      meas_start <= 1'b0;
      meas_settle <= 1'b0;
      meas_busy <= 1'b0;
      err_push <= 1'b0;
    end else begin
      trig_type <= next_trig_type;
      meas_start <= next_meas_start;
      meas_settle <= next_meas_settle;
      meas_busy <= next_meas_busy;
      err_push <= next_err_push;
    end
  end

  // ----------------------------------------------------------------
  // query answers and abort reply
  // ----------------------------------------------------------------
  tx_state_t tx_state, next_tx_state;
  logic [2:0] tx_idx, next_tx_idx;
  logic next_resp_valid, next_dev_clear, next_tx_valid;
  logic [31:0] next_resp_data;
  logic [7:0] next_tx_char;

  always_comb begin
    next_resp_valid = 1'b0;
    next_resp_data = resp_data;
    if (is_cmd(cmd_valid, cmd_code, CMD_QUERY_TRIG)) begin
      next_resp_valid = 1'b1;
      next_resp_data = {29'h0000_0000, trig_type};
    end else if (is_cmd(cmd_valid, cmd_code, CMD_SERIAL_QUERY)) begin
      next_resp_valid = 1'b1;
      next_resp_data = SERIAL_NUMBER;
    end
    next_dev_clear = clear_now;
    next_tx_state = tx_state;
    next_tx_idx = tx_idx;
    unique case (tx_state)
      TX_IDLE: next_tx_state = TX_IDLE;
      TX_SEND: begin
        if (tx_ready) begin
          if (tx_idx == ABORT_LAST) begin
            next_tx_state = TX_IDLE;
          end else begin
            next_tx_idx = tx_idx + 3'h1;
          end
        end
      end
    endcase
    // a second abort mid-reply restarts the sequence
    if (clear_now) begin
      next_tx_state = TX_SEND;
      next_tx_idx = 3'h0;
    end
    next_tx_valid = (next_tx_state == TX_SEND);
    next_tx_char = abort_char_at(next_tx_idx);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state <= TX_IDLE;
      tx_idx <= 3'h0;
      resp_valid <= 1'b0;
      resp_data <= 32'h0000_0000;
      dev_clear <= 1'b0;
      tx_valid <= 1'b0;
      tx_char <= CHAR_CR;
    end else begin
      tx_state <= next_tx_state;
      tx_idx <= next_tx_idx;
      resp_valid <= next_resp_valid;
      resp_data <= next_resp_data;
      dev_clear <= next_dev_clear;
      tx_valid <= next_tx_valid;
      tx_char <= next_tx_char;
    end
  end

  // ----------------------------------------------------------------
  // remote/local panel state
  // ----------------------------------------------------------------
  panel_t panel, next_panel;
  logic panel_cmd_ok;
  logic next_remote, next_lockout, next_keys_enabled, next_local_key_enabled;
  logic next_show_local_label, next_show_locked;

  always_comb begin
    panel_cmd_ok = cmd_valid && serial_enabled && cmd_iface == IFACE_SERIAL;
    next_panel = panel;
    if (panel_cmd_ok) begin
      unique case (cmd_code)
        CMD_REMOTE_STATE: next_panel = PANEL_REMOTE;
        CMD_REMOTE_LOCKOUT: next_panel = PANEL_REMOTE_LOCK;
        CMD_LOCAL_STATE: next_panel = PANEL_LOCAL;
        CMD_LOCAL_LOCKOUT: next_panel = PANEL_LOCAL_LOCK;
        default: next_panel = panel;
      endcase
    end
    next_remote = (next_panel == PANEL_REMOTE) || (next_panel == PANEL_REMOTE_LOCK);
    next_lockout = (next_panel == PANEL_REMOTE_LOCK) || (next_panel == PANEL_LOCAL_LOCK);
    next_keys_enabled = (next_panel == PANEL_LOCAL);
    next_local_key_enabled = (next_panel == PANEL_LOCAL) || (next_panel == PANEL_REMOTE);
    next_show_local_label = (next_panel == PANEL_REMOTE);
    next_show_locked = (next_panel == PANEL_REMOTE_LOCK);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      panel <= PANEL_LOCAL;
      remote <= 1'b0;
      lockout <= 1'b0;
      keys_enabled <= 1'b1;
      local_key_enabled <= 1'b1;
      show_local_label <= 1'b0;
      show_locked <= 1'b0;
    end else begin
      panel <= next_panel;
      remote <= next_remote;
      lockout <= next_lockout;
      keys_enabled <= next_keys_enabled;
      local_key_enabled <= next_local_key_enabled;
      show_local_label <= next_show_local_label;
      show_locked <= next_show_locked;
    end
  end

  // ----------------------------------------------------------------
  // error queue
  // ----------------------------------------------------------------
  error_queue i_error_queue (
    .clk(clk),
    .reset(reset),
    .push(err_push),
    .push_code(ERR_EXEC),
    .pop(err_read),
    .clear(err_clear),
    .pop_valid(err_valid),
    .pop_code(err_code),
    .count(err_count)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_bad_type;
    @(posedge clk) disable iff (reset)
      (is_cmd(cmd_valid, cmd_code, CMD_SET_TRIG) && !type_ok) |=> ($stable(trig_type) && err_push);
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("bad trigger type changed state or raised no error");
  property p_type_range;
    @(posedge clk) disable iff (reset) (trig_type >= TRIG_INTERNAL) && (trig_type <= TRIG_EXT_DELAY_B);
  endproperty
  a_type_range: assert property (p_type_range) else $error("trigger type out of range");
  property p_internal_runs;
    @(posedge clk) disable iff (reset)
      (trig_type == TRIG_INTERNAL && !meas_busy && !clear_now) |=> meas_start;
  endproperty
  a_internal_runs: assert property (p_internal_runs) else $error("internal trigger did not start");
  property p_settle;
    @(posedge clk) disable iff (reset) meas_start |-> (meas_settle == has_delay($past(trig_type)));
  endproperty
  a_settle: assert property (p_settle) else $error("settling delay does not match type");
  property p_query;
    @(posedge clk) disable iff (reset)
      is_cmd(cmd_valid, cmd_code, CMD_QUERY_TRIG) |=> (resp_valid && resp_data[2:0] == $past(trig_type));
  endproperty
  a_query: assert property (p_query) else $error("trigger query returned wrong type");
  property p_busy_blocks;
    @(posedge clk) disable iff (reset) meas_start |=> (!meas_start && meas_busy) || $past(clear_now);
  endproperty
  a_busy_blocks: assert property (p_busy_blocks) else $error("trigger accepted while busy");
  property p_rear_edge;
    @(posedge clk) disable iff (reset) (rear_fall && !meas_busy && !clear_now) |=> meas_start;
  endproperty
  a_rear_edge: assert property (p_rear_edge) else $error("rear edge did not start measurement");

  property p_get_serial;
    @(posedge clk) disable iff (reset)
      (trig_type != TRIG_INTERNAL && !rear_fall && is_cmd(cmd_valid, cmd_code, CMD_BUS_GET)
       && cmd_iface == IFACE_SERIAL) |=> !meas_start;
  endproperty
  a_get_serial: assert property (p_get_serial) else $error("group trigger acted on serial");

  property p_abort_reply;
    @(posedge clk) disable iff (reset)
      clear_now |=> (dev_clear && tx_valid && tx_char == CHAR_CR);
  endproperty
  a_abort_reply: assert property (p_abort_reply) else $error("abort reply did not begin");

  property p_panel_gate;
    @(posedge clk) disable iff (reset) (cmd_valid && !serial_enabled) |=> $stable(panel);
  endproperty
  a_panel_gate: assert property (p_panel_gate) else $error("panel changed with serial disabled");

  property p_lockout_view;
    @(posedge clk) disable iff (reset)
      (panel_cmd_ok && cmd_code == CMD_REMOTE_LOCKOUT) |=> (show_locked && !keys_enabled && !local_key_enabled);
  endproperty
  a_lockout_view: assert property (p_lockout_view) else $error("lockout not shown");
endmodule : trigger_remote_ctrl

`default_nettype wire
